/* File: pkg/isp_map.vh */
/*
  constants for the two-wire slave register port: bit counts, pointer reset,
  default slave address. assumes plain verilog-2005 includers.
*/
`ifndef ISP_MAP_VH
`define ISP_MAP_VH

// bits per byte on the wire
`define ISP_BYTE_BITS 4'h8
// acknowledge slot index within a byte frame
`define ISP_ACK_SLOT 4'h8
// slave address width
`define ISP_ADDR_BITS 7
// default slave address, arbitrary value
`define ISP_SLAVE_ADDR 7'h2a
// register pointer value after reset
`define ISP_PTR_RST 8'h00

`endif

/* File: rtl/isp_line_watch.v */
/*
  line watcher: samples scl and sda, reports edges, start and stop.
  assumes scl and sda are synchronous to sys_clk.
*/
`timescale 1ns/1ps
module isp_line_watch (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // bus lines
  input wire scl_in,
  input wire sda_in,
  // decoded events
  output reg scl_rise,
  output reg scl_fall,
  output reg start_det,
  output reg stop_det,
  output reg sda_lvl
);

  reg scl_r;
  reg sda_r;

  // remember previous levels and flag transitions
  always @(posedge sys_clk) begin
    if (rst) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      start_det <= 1'b0;
      stop_det <= 1'b0;
      sda_lvl <= 1'b1;
    end else begin
      scl_r <= scl_in;
      sda_r <= sda_in;
      sda_lvl <= sda_in;
      scl_rise <= scl_in & ~scl_r;
      scl_fall <= ~scl_in & scl_r;
      start_det <= scl_in & scl_r & sda_r & ~sda_in;
      stop_det <= scl_in & scl_r & ~sda_r & sda_in;
    end
  end

endmodule // isp_line_watch

/* File: rtl/isp_slave_port.v */
/*
  two-wire slave port giving a master access to 8-bit registers.
  bytes are framed by scl edges seen in the sys_clk domain; the port
  answers with an open-drain pull on sda (sda_oe high pulls low).
  assumes a register file outside: writes leave on reg_wr_*, read data
  returns on reg_rd_data combinationally for reg_ptr.
  assumes scl and sda already synchronous to sys_clk, each scl half period
  at least four clocks long, and no clock stretching by this port.
*/
// How it works
// - after start the first seven bits are compared with our own address
// - eighth bit one means we transmit, zero means we receive
// - on address match we pull sda low in the acknowledge slot
// - we acknowledge the register address and each data byte, storing data
// - pointer increments by one after each acknowledged written data byte
// - in a read we send bytes, incrementing pointer on each master acknowledge
// - bytes are eight bits, msb first, then acknowledge by the receiver
// - sda change while scl high mid-transaction abandons the transaction
`timescale 1ns/1ps
`include "isp_map.vh"
module isp_slave_port #(
  parameter [6:0] SLAVE_ADDR = `ISP_SLAVE_ADDR
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // two-wire bus, open drain sda
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // register file side
  output reg [7:0] reg_ptr,
  output reg reg_wr_en,
  output reg [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data,
  // status
  output reg busy
);

  // byte level states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_PTR = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_ACK = 3'h5;
  localparam [2:0] ST_MACK = 3'h6;

  // events from the line watcher
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire sda_lvl;

  // frame state
  reg [2:0] state_r;
  reg [2:0] after_ack_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg scl_hi_r;
  reg sda_hold_r;
  reg wr_done_r; // a data byte was stored in the current slot

  isp_line_watch u_watch (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_lvl(sda_lvl)
  );

  // a level change within one scl high phase that is not a start or stop
  // is caught by comparing with the level seen at the rising edge; the
  // falling edge cycle is left out because the master may move sda with it
  wire glitch = scl_hi_r & ~scl_rise & ~scl_fall & (sda_lvl != sda_hold_r) &
    ~start_det & ~stop_det;

  // byte state machine, advanced on scl edges
  always @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      scl_hi_r <= 1'b0;
      sda_hold_r <= 1'b1;
      wr_done_r <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      reg_ptr <= `ISP_PTR_RST;
      reg_wr_en <= 1'b0;
      reg_wr_data <= 8'h00;
      busy <= 1'b0;
    end else begin
      reg_wr_en <= 1'b0;
      if (scl_rise) begin
        scl_hi_r <= 1'b1;
        sda_hold_r <= sda_lvl;
      end else if (scl_fall) begin
        scl_hi_r <= 1'b0;
      end else if (start_det || stop_det) begin
        // a start or stop sets the level that the rest of the high time keeps
        sda_hold_r <= sda_lvl;
      end
      if (start_det) begin
        // start or repeated start: listen for an address
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        wr_done_r <= 1'b0;
        sda_oe <= 1'b0;
        busy <= 1'b1;
      end else if (stop_det) begin
        // a stop, also inside a byte, drops whatever was under way
        state_r <= ST_IDLE;
        sda_oe <= 1'b0;
        busy <= 1'b0;
      end else if (glitch && state_r != ST_IDLE) begin
        state_r <= ST_IDLE;
        sda_oe <= 1'b0;
        busy <= 1'b0;
      end else begin
        case (state_r)
          // receive: shift on rising scl, decide after the eighth bit
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_lvl};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == `ISP_BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == SLAVE_ADDR) begin
                  sda_out <= 1'b0;
                  sda_oe <= 1'b1;
                  state_r <= ST_ACK;
                  after_ack_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                  if (shift_r[0])
                    tx_r <= reg_rd_data;
                end else begin
                  state_r <= ST_IDLE;
                  busy <= 1'b0;
                end
              end else begin
                sda_out <= 1'b0;
                sda_oe <= 1'b1;
                state_r <= ST_ACK;
                after_ack_r <= ST_WDATA;
                if (state_r == ST_PTR) begin
                  reg_ptr <= shift_r;
                end else begin
                  reg_wr_data <= shift_r;
                  reg_wr_en <= 1'b1;
                  wr_done_r <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            // release, or drive the first bit of a read byte, at the end of the acknowledge slot
            if (scl_fall) begin
              state_r <= after_ack_r;
              bit_cnt_r <= 4'h0;
              if (after_ack_r == ST_RDATA) begin
                sda_out <= tx_r[7];
                sda_oe <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
              end else begin
                sda_oe <= 1'b0;
              end
              // a stored data byte moves the pointer once its slot has ended
              if (wr_done_r)
                reg_ptr <= reg_ptr + 8'h01;
              wr_done_r <= 1'b0;
            end
          end
          // transmit: next bit after each falling edge, release after the eighth
          ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt_r == `ISP_BYTE_BITS) begin
                sda_oe <= 1'b0; // release for master acknowledge
                state_r <= ST_MACK;
              end else begin
                sda_out <= tx_r[7];
                sda_oe <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          // master acknowledge decides whether another byte follows
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_lvl) begin
                state_r <= ST_IDLE;
                busy <= 1'b0;
              end else begin
                reg_ptr <= reg_ptr + 8'h01;
                state_r <= ST_ACK;
                after_ack_r <= ST_RDATA;
              end
            end
          end
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
      // load next read byte once the pointer has moved
      if (state_r == ST_ACK && after_ack_r == ST_RDATA && !scl_fall && !scl_rise)
        tx_r <= reg_rd_data;
    end
  end

endmodule // isp_slave_port

/* File: sim/isp_slave_port_monitor.sv */
/* protocol checker on the slave port pins.
   assumes it is bound to isp_slave_port. */
`timescale 1ns/1ps
module isp_slave_port_monitor (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // bus and register side
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [7:0] reg_ptr,
  input wire reg_wr_en,
  input wire busy
);
  // all checks sample on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
  a_rise: assert property (p_rise) else $error("drive began, scl high");
  property p_hold; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("drive moved, scl high");
  property p_slot; $rose(sda_oe) |-> sda_oe[*6]; endproperty
  a_slot: assert property (p_slot) else $error("drive too short");
  property p_pull; sda_oe |-> !sda_out && busy; endproperty
  a_pull: assert property (p_pull) else $error("drive while idle");
  property p_pulse; reg_wr_en |=> !reg_wr_en; endproperty
  a_pulse: assert property (p_pulse) else $error("store pulse long");
  property p_wbusy; reg_wr_en |-> busy; endproperty
  a_wbusy: assert property (p_wbusy) else $error("store while idle");
  // pointer as it stood at the last store, for the step check
  reg [7:0] ptr_at_wr_r;
  always @(posedge sys_clk) begin
    if (rst)
      ptr_at_wr_r <= 8'h00;
    else if (reg_wr_en)
      ptr_at_wr_r <= reg_ptr;
  end
  property p_inc; reg_wr_en |-> ##[8:30] reg_ptr == ptr_at_wr_r + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("pointer not stepped");
  property p_stop; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !busy; endproperty
  a_stop: assert property (p_stop) else $error("busy after stop");
  property p_start; scl_in && $past(scl_in) && $fell(sda_in) |=> (!sda_oe)[*4]; endproperty
  a_start: assert property (p_start) else $error("drive after start");
endmodule // isp_slave_port_monitor
bind isp_slave_port isp_slave_port_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en), .busy(busy));

/* File: sim/isp_bus_master.sv */
/* bus master model with start, stop and byte tasks.
   assumes sda_w is the resolved wire with a pull-up. */
`timescale 1ns/1ps
module isp_bus_master (
  // clock
  input wire sys_clk,
  // bus
  output reg scl = 1'b1,
  output reg sda_m = 1'b1,
  input wire sda_w
);
  // half scl period of six clocks
  task hp;
    begin
      repeat (6) @(posedge sys_clk);
      #1;
    end
  endtask
  // start or repeated start, scl left low
  task go;
    begin
      sda_m = 1'b1;
      hp;
      scl = 1'b1;
      hp;
      sda_m = 1'b0;
      hp;
      scl = 1'b0;
    end
  endtask
  // stop from scl low
  task sp;
    begin
      sda_m = 1'b0;
      hp;
      scl = 1'b1;
      hp;
      sda_m = 1'b1;
      hp;
    end
  endtask
  // one bit, sampled late in scl high
  task bt(input b, output r);
    begin
      sda_m = b;
      hp;
      scl = 1'b1;
      hp;
      r = sda_w;
      scl = 0;
    end
  endtask
  // byte msb first, then the ninth slot with ma
  task xb(input [7:0] d, input ma, output [7:0] q, output ak);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bt(d[k], q[k]);
      bt(ma, ak);
    end
  endtask
endmodule // isp_bus_master

/* File: sim/isp_slave_port_tb.sv */
/* self-checking bench for the slave port.
   assumes the shared constants header is on the include path. */
`timescale 1ns/1ps
`include "isp_map.vh"
module isp_slave_port_tb;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  wire scl, sda_m, sda_out, sda_oe, reg_wr_en, busy;
  wire [7:0] reg_ptr, reg_wr_data;
  wire sda_w = sda_m & ~(sda_oe & ~sda_out);
  reg [7:0] mem [0:255];
  reg [7:0] em [0:255];
  wire [7:0] reg_rd_data = mem[reg_ptr];
  reg [15:0] q [$];
  reg [31:0] rnd = 32'h007a8785;
  integer err_total = 0, n_checks = 0, cyc = 0, i;
  reg [7:0] got, d;
  reg a;
  always #10 sys_clk = ~sys_clk;
  isp_bus_master m (.sys_clk(sys_clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
  isp_slave_port u_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .busy(busy));
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task ack(input e);
    chk("ack", {15'h0, e}, {15'h0, a});
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // register file and store watcher against the oldest note
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 12000) begin
      err_total = err_total + 1;
      stop_test;
    end else if (reg_wr_en === 1'b1) begin
      mem[reg_ptr] <= reg_wr_data;
      if (q.size() == 0) chk("spur", 16'h0, {15'h0, reg_wr_en});
      else chk("store", q.pop_front(), {reg_ptr, reg_wr_data});
    end
  end
  task wr_burst(input [7:0] pt, input integer n);
    begin
      m.go;
      m.xb({`ISP_SLAVE_ADDR, 1'b0}, 1'b1, got, a);
      ack(1'b0);
      m.xb(pt, 1'b1, got, a);
      ack(1'b0);
      for (i = 0; i < n; i = i + 1) begin
        rnd = nx(rnd);
        d = rnd[7:0];
        em[pt + i[7:0]] = d;
        q.push_back({pt + i[7:0], d});
        m.xb(d, 1'b1, got, a);
        ack(1'b0);
      end
      m.sp;
    end
  endtask
  task rd_burst(input [7:0] pt, input integer n);
    begin
      m.go;
      m.xb({`ISP_SLAVE_ADDR, 1'b0}, 1'b1, got, a);
      m.xb(pt, 1'b1, got, a);
      m.go;
      m.xb({`ISP_SLAVE_ADDR, 1'b1}, 1'b1, got, a);
      ack(1'b0);
      for (i = 0; i < n; i = i + 1) begin
        m.xb(8'hff, i == n - 1, got, a);
        chk("rdat", {8'h0, em[pt + i[7:0]]}, {8'h0, got});
      end
      m.sp;
    end
  endtask
  // main sequence: bursts at 05 and across the pointer wrap, then a foreign address
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      mem[i] = i[7:0];
      em[i] = i[7:0];
    end
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    wr_burst(8'h05, 2);
    wr_burst(8'hfe, 3);
    rd_burst(8'hfd, 5);
    rd_burst(8'h05, 1);
    m.go;
    m.xb({`ISP_SLAVE_ADDR ^ 7'h01, 1'b1}, 1'b1, got, a);
    ack(1'b1);
    chk("busy", 16'h0, {15'h0, busy});
    m.xb(8'h10, 1'b1, got, a);
    ack(1'b1);
    m.sp;
    // a stop inside a data byte abandons it: no store and no pointer step
    m.go;
    m.xb({`ISP_SLAVE_ADDR, 1'b0}, 1'b1, got, a);
    ack(1'b0);
    m.xb(8'h40, 1'b1, got, a);
    ack(1'b0);
    for (i = 0; i < 4; i = i + 1)
      m.bt(1'b1, a);
    chk("busy", 16'h1, {15'h0, busy});
    m.sp;
    chk("busy", 16'h0, {15'h0, busy});
    chk("ptr", 16'h0040, {8'h0, reg_ptr});
    repeat (20) @(posedge sys_clk);
    chk("left", 16'h0, 16'(q.size()));
    stop_test;
  end
endmodule // isp_slave_port_tb
